// ---- shared/idle_map.svh ----
/*
 * offsets, opcodes, bit positions, page constants and timer figures
 * for the identify page and idle timer block; assumes a 16-bit task
 * file with 3-bit register addresses
 */
`ifndef IDLE_MAP_SVH
`define IDLE_MAP_SVH
// ==========================================================
// task file addresses (command shares the status address)
`define A_DATA 3'h0
`define A_ERR 3'h1
`define A_SCNT 3'h2
`define A_STAT 3'h7
// ==========================================================
// opcodes
`define OP_IDLE_A 8'hE3
`define OP_IDLE_B 8'h97
`define OP_IDENT 8'hEC
// ==========================================================
// status and error bits
`define ST_RDY 6
`define ST_DSC 4
`define ST_DRQ 3
`define ST_ERR 0
`define ERR_ABT 8'h04
// ==========================================================
// fixed page words and fields
`define W50 16'h4000
`define W51 16'h0200
`define W53 16'h0007
`define W63_LO 8'h07
`define W64 16'h0003
`define W65 16'h0078
`define W67 16'h00F0
`define W80 16'h003C
`define W81 16'h0015
`define W82 16'h74EB
`define W83 16'h43EA
`define W_VALID 16'h4000
`define W88_LO 8'h3F
`define W92 16'hFFFE
`define SEC_MASK 9'h13F
`define SIG 8'hA5
`define LAST_W 8'hFF
`define LIVE_W 8'h32
// ==========================================================
// standby timer encoding, times in seconds
`define SHORT_STEP_S 5
`define LONG_STEP_S 1800
`define SHORT_MAX 8'hF0
`define LONG_MAX 8'hFB
`define C252 8'hFC
`define C253 8'hFD
`define C254 8'hFE
`define C252_S 1260
`define C253_S 28800
`define C254_S 1270
`define C255_S 1275
// ==========================================================
// clock and second tick
`define CLK_NS 10
`define SEC_NS 1000000000
`define SEC_CYCLES (`SEC_NS / `CLK_NS)
`endif

// ---- shared/idle_pkg.sv ----
/*
 * types for the identify page and idle timer block; assumes the
 * drive firmware supplies the live page fields as one struct
 */
package idle_pkg;
   // live identify fields, all levels from the drive
   typedef struct packed {
      logic [15:0] cyls;
      logic [15:0] heads;
      logic [15:0] spt;
      logic [31:0] cur_cap;
      logic mult_ok;
      logic [7:0] mult_cnt;
      logic [31:0] total;
      logic [7:0] mdma_act;
      logic udma_on;
      logic [2:0] udma_mode;
      logic [4:0] qdepth;
      logic [15:0] erase_t;
      logic [7:0] aam_rec;
      logic [7:0] aam_cur;
      logic [8:0] sec_bits;
      logic [3:0] opts;
      logic [15:0] en85;
      logic [15:0] en86;
   } ident_live_s;
   // command engine states
   typedef enum logic [1:0] {
      ST_READY = 2'h1,
      ST_XFER = 2'h2
   } cmd_state_e;
endpackage

// ---- src/idle_ident.sv ----
/*
 * task-file command logic for the identify page (words 50..255, words
 * below come from the drive) and the idle command with its standby
 * timer; assumes host strobes are synchronous one-cycle pulses
 */
// How it works
// - Both idle opcodes do the same thing
// - Idle enters idle and loads standby timer
// - Spin up only when spindle is stopped
// - Zero count disables auto power-down
// - 1-240 five seconds, 241-251 half hours
// - Codes 252 to 255 are special times
// - Timer expiry without access enters standby
// - Any host access restarts the countdown
// - Word 50 valid bit, minimum timer flag clear
// - Word 53 flags words 88, 64-70, 54-58
// - Words 54-58 give current geometry, capacity
// - Word 59 multiple setting valid and count
// - Words 60-61 total addressable sectors
// - Word 63 active mode high, 07 low
// - Words 64-68 PIO modes and cycle times
// - Words 82-86 feature support and enables
// - Word 88 one-hot active Ultra mode
// - Word 89 erase time in two minutes
// - Word 94 recommended and current acoustics
// - Word 128 security state bits
// - Word 129 current feature options
// - Word 255 signature and page checksum
// - Identify sends one 256-word sector
`timescale 1ns/1ps
`include "idle_map.svh"
module idle_ident #(
   parameter int unsigned SEC_CYCLES = `SEC_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // task file
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [2:0] addr_i,
   input wire logic [15:0] wdata_i,
   output logic [15:0] rdata_o,
   // drive side
   input wire idle_pkg::ident_live_s live_i,
   input wire logic [15:0] low_word_i,
   output logic [7:0] word_idx_o,
   input wire logic spinning_i,
   output logic spin_up_o,
   output logic idle_o,
   output logic standby_o
);
   // ==========================================================
   // state
   idle_pkg::cmd_state_e state; // command engine
   logic [7:0] scnt; // sector count register
   logic [7:0] err; // error register
   logic err_st; // status error bit
   logic [7:0] csum; // running byte sum of sent words
   logic timer_en; // auto power-down armed
   logic [14:0] sec_load; // interval kept for reloads
   logic [14:0] sec_left; // seconds still to run
   logic [31:0] div; // second divider

   // ==========================================================
   // decode
   wire cmd_wr = wr_i && addr_i == `A_STAT;
   wire [7:0] op = wdata_i[7:0];
   wire is_idle = op == `OP_IDLE_A || op == `OP_IDLE_B;
   wire is_ident = op == `OP_IDENT;
   wire busy_xfer = state == idle_pkg::ST_XFER;
   // idle refused while a page transfer is open
   wire idle_ok = cmd_wr && is_idle && !busy_xfer;
   wire ident_ok = cmd_wr && is_ident && !busy_xfer;
   wire reject = cmd_wr && !idle_ok && !ident_ok;
   wire host_acc = wr_i || rd_i;
   wire data_rd = rd_i && addr_i == `A_DATA && busy_xfer;
   // an access in the expiry cycle wins, so the countdown restarts
   wire tick = timer_en && !standby_o && !host_acc &&
      div == 32'(SEC_CYCLES - 1);
   wire last_w = word_idx_o == `LAST_W;
   wire [7:0] ck_byte = 8'h00 - (csum + `SIG);

   // ==========================================================
   // timer code to seconds
   function automatic logic [14:0] secs(input logic [7:0] v);
      logic [14:0] r;
      r = 15'h0000;
      if (v <= `SHORT_MAX) begin
         r = 15'(15'(v) * 15'(`SHORT_STEP_S));
      end else if (v <= `LONG_MAX) begin
         r = 15'(15'(v - `SHORT_MAX) * 15'(`LONG_STEP_S));
      end else if (v == `C252) begin
         r = 15'(`C252_S);
      end else if (v == `C253) begin
         r = 15'(`C253_S);
      end else if (v == `C254) begin
         r = 15'(`C254_S);
      end else begin
         r = 15'(`C255_S);
      end
      return r;
   endfunction

   wire [14:0] next_load = secs(scnt);

   // ==========================================================
   // page word select; words below 50 come from the drive
   wire [5:0] udma_hot = live_i.udma_on ?
      6'(6'h01 << live_i.udma_mode) : 6'h00;
   logic [15:0] page_w;
   always_comb begin
      unique case (word_idx_o)
         8'd50: page_w = `W50;
         8'd51, 8'd52: page_w = `W51;
         8'd53: page_w = `W53;
         8'd54: page_w = live_i.cyls;
         8'd55: page_w = live_i.heads;
         8'd56: page_w = live_i.spt;
         8'd57: page_w = live_i.cur_cap[15:0];
         8'd58: page_w = live_i.cur_cap[31:16];
         8'd59: page_w = {7'h00, live_i.mult_ok, live_i.mult_cnt};
         8'd60: page_w = live_i.total[15:0];
         8'd61: page_w = live_i.total[31:16];
         8'd63: page_w = {live_i.mdma_act, `W63_LO};
         8'd64: page_w = `W64;
         8'd65, 8'd66, 8'd68: page_w = `W65;
         8'd67: page_w = `W67;
         8'd75: page_w = {11'h000, live_i.qdepth};
         8'd80: page_w = `W80;
         8'd81: page_w = `W81;
         8'd82: page_w = `W82;
         8'd83: page_w = `W83;
         8'd84, 8'd87, 8'd93: page_w = `W_VALID;
         8'd85: page_w = live_i.en85 & `W82;
         8'd86: page_w = live_i.en86 & `W83 & 16'h03FF;
         8'd88: page_w = {2'h0, udma_hot, `W88_LO};
         8'd89: page_w = live_i.erase_t;
         8'd92: page_w = `W92;
         8'd94: page_w = {live_i.aam_rec, live_i.aam_cur};
         8'd128: page_w = {7'h00, live_i.sec_bits & `SEC_MASK};
         8'd129: page_w = {12'h000, live_i.opts};
         8'd255: page_w = {ck_byte, `SIG};
         // reserved words read zero
         default: page_w = (word_idx_o < `LIVE_W) ?
            low_word_i : 16'h0000;
      endcase
   end

   // ==========================================================
   // read mux of the task file
   wire [7:0] stat = {1'b0, 1'b1, 1'b0, 1'b1, busy_xfer, 2'h0,
      err_st};
   logic [15:0] next_rdata;
   always_comb begin
      unique case (addr_i)
         `A_DATA: next_rdata = busy_xfer ? page_w : 16'h0000;
         `A_ERR: next_rdata = {8'h00, err};
         `A_SCNT: next_rdata = {8'h00, scnt};
         `A_STAT: next_rdata = {8'h00, stat};
         default: next_rdata = 16'h0000;
      endcase
   end

   // registered read data, one cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= 16'h0000;
      end else if (rd_i) begin
         rdata_o <= next_rdata;
      end
   end

   // sector count register, host read/write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         scnt <= 8'h00;
      end else if (wr_i && addr_i == `A_SCNT) begin
         scnt <= wdata_i[7:0];
      end
   end

   // ==========================================================
   // command engine and page transfer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= idle_pkg::ST_READY;
         word_idx_o <= 8'h00;
         csum <= 8'h00;
      end else begin
         unique case (state)
            idle_pkg::ST_READY: begin
               if (ident_ok) begin
                  state <= idle_pkg::ST_XFER;
                  word_idx_o <= 8'h00;
                  csum <= 8'h00;
               end
            end
            idle_pkg::ST_XFER: begin
               if (data_rd) begin
                  csum <= csum + page_w[7:0] + page_w[15:8];
                  word_idx_o <= word_idx_o + 8'h01;
                  if (last_w) begin
                     state <= idle_pkg::ST_READY;
                  end
               end
            end
         endcase
      end
   end

   // error and status error bit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         err <= 8'h00;
         err_st <= 1'b0;
      end else if (reject) begin
         err <= `ERR_ABT;
         err_st <= 1'b1;
      end else if (idle_ok || ident_ok) begin
         err <= 8'h00;
         err_st <= 1'b0;
      end
   end

   // ==========================================================
   // idle entry, spin-up and standby entry
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         idle_o <= 1'b0;
         standby_o <= 1'b0;
         spin_up_o <= 1'b0;
      end else begin
         // spin-up pulse skipped when already turning
         spin_up_o <= idle_ok && !spinning_i;
         if (idle_ok) begin
            idle_o <= 1'b1;
            standby_o <= 1'b0;
         end else if (tick && sec_left == 15'h0001) begin
            idle_o <= 1'b0;
            standby_o <= 1'b1;
         end
      end
   end

   // standby countdown; an idle write loads, any access reloads
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_en <= 1'b0;
         sec_load <= 15'h0000;
         sec_left <= 15'h0000;
         div <= 32'h0000_0000;
      end else if (idle_ok) begin
         timer_en <= scnt != 8'h00;
         sec_load <= next_load;
         sec_left <= next_load;
         div <= 32'h0000_0000;
      end else if (host_acc) begin
         sec_left <= sec_load;
         div <= 32'h0000_0000;
      end else if (tick) begin
         div <= 32'h0000_0000;
         sec_left <= sec_left - 15'h0001;
      end else if (timer_en && !standby_o) begin
         div <= div + 32'h0000_0001;
      end
   end

   // ==========================================================
   // checks; each guards the logic above it
   chk_idle_both_ops: assert property (
      @(posedge clk_i) disable iff (rst_i)
      idle_ok |=> idle_o && !standby_o && err == 8'h00)
      else $error("idle opcode not taken");
   chk_idle_loads: assert property (
      @(posedge clk_i) disable iff (rst_i)
      idle_ok |=> sec_left == $past(next_load))
      else $error("timer not loaded on idle");
   chk_spinup_gate: assert property (
      @(posedge clk_i) disable iff (rst_i)
      spin_up_o |-> $past(idle_ok) && !$past(spinning_i))
      else $error("spin-up while turning");
   chk_spinup_skip: assert property (
      @(posedge clk_i) disable iff (rst_i)
      idle_ok && spinning_i |=> !spin_up_o && idle_o)
      else $error("spin-up pulse for a turning spindle");
   chk_zero_disable: assert property (
      @(posedge clk_i) disable iff (rst_i)
      idle_ok && scnt == 8'h00 |=> !timer_en)
      else $error("zero count left timer on");
   chk_code_short: assert property (
      @(posedge clk_i) disable iff (rst_i)
      idle_ok && scnt == 8'h01 |=> sec_load == 15'h0005)
      else $error("code 1 not 5 seconds");
   chk_code_long: assert property (
      @(posedge clk_i) disable iff (rst_i)
      idle_ok && scnt == 8'hF1 |=> sec_load == 15'h0708)
      else $error("code 241 not 30 minutes");
   chk_code_special: assert property (
      @(posedge clk_i) disable iff (rst_i)
      idle_ok && scnt == 8'hFD |=> sec_load == 15'h7080)
      else $error("code 253 not 8 hours");
   chk_code_odd: assert property (
      @(posedge clk_i) disable iff (rst_i)
      idle_ok && scnt == 8'hFE |=> sec_load == 15'h04F6)
      else $error("code 254 not 21 minutes 10 seconds");
   chk_standby_entry: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $rose(standby_o) |-> $past(timer_en) && !$past(host_acc) &&
      $past(sec_left) == 15'h0001)
      else $error("standby without expiry");
   chk_standby_holds: assert property (
      @(posedge clk_i) disable iff (rst_i)
      standby_o && !idle_ok |=> standby_o)
      else $error("standby left without idle command");
   chk_access_reload: assert property (
      @(posedge clk_i) disable iff (rst_i)
      host_acc && !idle_ok |=> sec_left == $past(sec_load) &&
      div == 32'h0000_0000)
      else $error("access did not restart timer");
   chk_word53_flags: assert property (
      @(posedge clk_i) disable iff (rst_i)
      data_rd && word_idx_o == 8'h35 |=> rdata_o == `W53)
      else $error("validity word wrong");
   chk_abort_flags: assert property (
      @(posedge clk_i) disable iff (rst_i)
      reject |=> err == `ERR_ABT && err_st)
      else $error("reject not reported");
   chk_page_end: assert property (
      @(posedge clk_i) disable iff (rst_i)
      data_rd && last_w |=> rdata_o[7:0] == `SIG && !busy_xfer)
      else $error("page end wrong");
   chk_page_start: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ident_ok |=> busy_xfer && word_idx_o == 8'h00)
      else $error("identify did not open page");
   cov_idle_spin: cover property (@(posedge clk_i)
      disable iff (rst_i) idle_ok ##1 spin_up_o);
   cov_standby: cover property (@(posedge clk_i)
      disable iff (rst_i) $rose(standby_o));
   cov_page_done: cover property (@(posedge clk_i)
      disable iff (rst_i) data_rd && last_w);
   cov_reject: cover property (@(posedge clk_i)
      disable iff (rst_i) reject);
endmodule

// ---- verification/host_adapter.sv ----
/*
 * host adapter model that drives the task file of the drive block;
 * assumes strobes are taken on the rising edge with no wait states
 */
`timescale 1ns/1ps
module host_adapter (
   // clock
   input wire logic clk_i,
   // task file strobes and buses
   output logic wr_o,
   output logic rd_o,
   output logic [2:0] addr_o,
   output logic [15:0] wdata_o
);
   // ======================================
   // bus quiet at time zero
   initial begin
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = 3'h0;
      wdata_o = 16'h0000;
   end
   // ======================================
   // one access: random gap, then a one-cycle strobe
   task automatic acc(input logic w, input logic [2:0] a,
         input logic [15:0] d);
      // a gap of 0..2 cycles plays a slow host as well as a prompt one
      repeat ($urandom_range(2, 0)) @(posedge clk_i);
      @(posedge clk_i);
      #1;
      wr_o = w;
      rd_o = ~w;
      addr_o = a;
      wdata_o = d;
      @(posedge clk_i);
      #1;
      // released lines must not keep showing the last value
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
   endtask
endmodule

// ---- verification/test_idle_ident.sv ----
/*
 * self-checking bench: reads the identify page and runs the idle timer;
 * assumes the host adapter model drives the task file
 */
`timescale 1ns/1ps
`include "idle_map.svh"
module test_idle_ident;
   // ======================================
   // signals
   localparam int SC = 4; // short second keeps the run small
   logic clk_i;
   logic rst_i;
   logic wr, rd, spinning, spin_up, idle, standby;
   logic [2:0] addr;
   logic [15:0] wdata, rdata, low_word;
   logic [7:0] idx;
   idle_pkg::ident_live_s live;
   logic [15:0] exp_q[$]; // expected read data, oldest first
   logic [7:0] codes[9] = '{8'h01, 8'hF0, 8'hF1, 8'hFC, 8'hFE, 8'hFF,
      8'h00, 8'hFD, 8'hFB};
   int mismatches = 0;
   int n_compared = 0;
   // low page words: a pattern of the index, from the drive
   assign low_word = {idx ^ 8'h5A, idx};
   // ======================================
   // instances
   host_adapter u_host_adapter (.clk_i(clk_i), .wr_o(wr), .rd_o(rd),
      .addr_o(addr), .wdata_o(wdata));
   idle_ident #(.SEC_CYCLES(SC)) u_idle_ident (.clk_i(clk_i),
      .rst_i(rst_i), .wr_i(wr), .rd_i(rd), .addr_i(addr),
      .wdata_i(wdata), .rdata_o(rdata), .live_i(live),
      .low_word_i(low_word), .word_idx_o(idx), .spinning_i(spinning),
      .spin_up_o(spin_up), .idle_o(idle), .standby_o(standby));
   // ======================================
   // clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // ======================================
   // helpers
   task automatic check(input string n, input logic [15:0] s,
         input logic [15:0] e);
      n_compared++;
      if (s !== e) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", n, e, s);
      end
   endtask
   task automatic conclude();
      // let the last read reach the monitor
      @(posedge clk_i);
      #5;
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
      u_host_adapter.acc(1'b1, a, d);
   endtask
   task automatic rd_reg(input logic [2:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      u_host_adapter.acc(1'b0, a, 16'h0000);
   endtask
   task automatic do_reset();
      rst_i = 1'b1;
      repeat (2) @(posedge clk_i);
      #1;
      rst_i = 1'b0;
   endtask
   // timeout in seconds for a sector count code
   function automatic int secs(input logic [7:0] c);
      if (c <= 8'hF0) return c * 5;
      if (c <= 8'hFB) return (c - 240) * 1800;
      case (c)
         8'hFC: return 1260;
         8'hFD: return 28800;
         8'hFE: return 1270;
         default: return 1275;
      endcase
   endfunction
   // expected page word
   function automatic logic [15:0] pw(input int i);
      logic [7:0] k;
      logic [5:0] oh;
      k = i[7:0];
      oh = live.udma_on ? 6'h01 << live.udma_mode : 6'h00;
      case (i)
         50: return 16'h4000;
         51, 52: return 16'h0200;
         53: return 16'h0007;
         54: return live.cyls;
         55: return live.heads;
         56: return live.spt;
         57: return live.cur_cap[15:0];
         58: return live.cur_cap[31:16];
         59: return {7'h00, live.mult_ok, live.mult_cnt};
         60: return live.total[15:0];
         61: return live.total[31:16];
         63: return {live.mdma_act, 8'h07};
         64: return 16'h0003;
         65, 66, 68: return 16'h0078;
         67: return 16'h00F0;
         75: return {11'h000, live.qdepth};
         80: return 16'h003C;
         81: return 16'h0015;
         82: return 16'h74EB;
         83: return 16'h43EA;
         84, 87, 93: return 16'h4000;
         85: return live.en85 & 16'h74EB;
         86: return live.en86 & 16'h03EA;
         88: return {2'h0, oh, 8'h3F};
         89: return live.erase_t;
         92: return 16'hFFFE;
         94: return {live.aam_rec, live.aam_cur};
         128: return {7'h00, live.sec_bits[8], 2'h0, live.sec_bits[5:0]};
         129: return {12'h000, live.opts};
         default: return (i < 50) ? {k ^ 8'h5A, k} : 16'h0000;
      endcase
   endfunction
   // one idle command, then time the standby entry
   task automatic idle_run(input logic [7:0] c, input logic [7:0] op,
         input int poke);
      int t;
      int n;
      int lim;
      logic ok;
      t = secs(c) * SC;
      lim = (t == 0 || t > 8000) ? 300 : t + 4;
      wr_reg(`A_SCNT, {8'h00, c});
      rd_reg(`A_SCNT, {8'h00, c});
      wr_reg(`A_STAT, {8'h00, op});
      // the command edge has just passed; the spin-up pulse lasts one cycle
      check("mode", {13'h0, spin_up, idle, standby},
         {13'h0, ~spinning, 2'b10});
      if (poke > 0) begin
         repeat (poke) @(posedge clk_i);
         rd_reg(`A_STAT, 16'h0050);
      end
      n = 0;
      while (standby !== 1'b1 && n < lim) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      ok = (n >= t - 1 && n <= t + 1);
      if (lim == 300) begin
         check("standby", {15'h0, standby}, 16'h0000);
      end else if (n >= lim) begin
         mismatches++;
         conclude();
      end else begin
         check("delay", {15'h0, ok}, 16'h0001);
         check("idle", {14'h0, idle, standby}, 16'h0001);
      end
   endtask
   // ======================================
   // monitor: each read result against the oldest note
   always @(posedge clk_i) begin
      if (rd === 1'b1) begin
         #2;
         check("read data", rdata, exp_q.pop_front());
      end
   end
   // ======================================
   // main sequence
   initial begin
      logic [223:0] r;
      logic [15:0] w;
      logic [7:0] sum;
      rst_i = 1'b1;
      spinning = 1'b0;
      void'($urandom(32'h9016));
      r = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom,
         $urandom};
      live = r[$bits(live)-1:0];
      live.udma_mode = 3'($urandom_range(5, 0));
      do_reset();
      // quiet after reset
      rd_reg(`A_STAT, 16'h0050);
      rd_reg(`A_ERR, 16'h0000);
      rd_reg(`A_DATA, 16'h0000);
      // whole page, checksum from the expected bytes
      wr_reg(`A_STAT, {8'h00, `OP_IDENT});
      rd_reg(`A_STAT, 16'h0058);
      sum = 8'h00;
      for (int i = 0; i < 255; i++) begin
         w = pw(i);
         sum = sum + w[7:0] + w[15:8];
         rd_reg(`A_DATA, w);
      end
      rd_reg(`A_DATA, {8'h00 - sum - 8'hA5, 8'hA5});
      rd_reg(`A_STAT, 16'h0050);
      rd_reg(`A_DATA, 16'h0000);
      // opcode outside this block is aborted
      wr_reg(`A_STAT, 16'h00E1);
      rd_reg(`A_ERR, {8'h00, `ERR_ABT});
      rd_reg(`A_STAT, 16'h0051);
      // every code class, both opcodes, spindle both ways
      foreach (codes[k]) begin
         spinning = k[0];
         idle_run(codes[k], k[0] ? 8'h97 : 8'hE3, 0);
      end
      idle_run(8'($urandom_range(60, 1)), 8'hE3, 0);
      idle_run(8'h02, 8'h97, 25);
      rd_reg(`A_ERR, 16'h0000);
      rd_reg(`A_STAT, 16'h0050);
      // reset after standby entry drops standby, with idle already low
      do_reset();
      check("after reset", {14'h0, idle, standby}, 16'h0000);
      conclude();
   end
endmodule
